// >>> rtl/afm_fault_monitor.v
// Fault status, system monitor, GPIO and low-side switch control of the converter
`timescale 1ns/1ps
`include "afm_consts.vh"

module afm_fault_monitor (
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  input  wire       ce_i,
  input  wire       por_event_i,
  input  wire       regmap_busy_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  input  wire       data_rd_start_i,
  output wire       data_first_is_status_o,
  output reg  [7:0] data_status_byte_o,
  input  wire       conversion_ready_signal_i,
  input  wire       sleep_command_i,
  input  wire       amp_bypassed_i,
  input  wire [3:0] rail_cmp_amp_i,
  input  wire [3:0] rail_cmp_adc_i,
  input  wire       ref_below_fixed_i,
  input  wire       ref_below_third_i,
  input  wire [3:0] gpio_pin_i,
  output reg  [3:0] gpio_out_o,
  output reg  [3:0] gpio_oe_o,
  output reg  [3:0] gpio_function_select_o,
  output reg  [2:0] monitor_select_o,
  output reg        inputs_disconnect_o,
  output reg        force_unity_gain_o,
  output reg        route_temp_o,
  output reg        route_analog_supply_o,
  output reg        route_logic_supply_o,
  output reg  [2:0] supply_divider_o,
  output reg  [2:0] burnout_sources_o,
  output reg        burnout_source_pos_o,
  output reg        burnout_sink_neg_o,
  output reg        ref_pull_together_o,
  output reg  [1:0] reference_monitor_enable_o,
  output reg        low_side_switch_close_o
);

////////////////////////////////////////////////////////////////////////////////
// Registers

  reg  [7:0] sysctl_q;
  reg  [7:0] exc1_q;
  reg  [7:0] refctl_q;
  reg  [7:0] gpio_dat_q;
  reg  [7:0] gpio_con_q;
  reg        por_flag_q;
  reg  [3:0] rail_flag_q;
  reg  [3:0] rail_cap_q;
  reg  [1:0] ref_flag_q;
  reg  [1:0] ref_cap_q;
  reg        sleep_q;
  reg  [1:0] conversion_ready_signal_sync_q;
  reg        conversion_ready_signal_prev_q;
  reg  [3:0] pin_meta_q;
  reg  [3:0] pin_sync_q;
  reg  [3:0] rail_meta_q;
  reg  [3:0] rail_sync_q;
  reg  [3:0] adc_meta_q;
  reg  [3:0] adc_sync_q;
  reg  [1:0] ref_meta_q;
  reg  [1:0] ref_sync_q;
  reg  [1:0] por_meta_q;
  reg  [1:0] busy_meta_q;
  reg  [1:0] misc_meta_q;
  reg  [1:0] misc_sync_q;
  wire       conversion_ready_signal_fall;
  wire [3:0] rail_live;
  wire [1:0] ref_live;
  wire [7:0] status_byte;
  wire [2:0] mon_sel;
  wire [3:0] gpio_rd_val;

  function wr_hit;
    input [7:0] addr;
    input [7:0] target;
    input       wr;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  // Monitor codes that route a supply reading to the converter
  function is_supply_mon;
    input [2:0] sel;
    begin
      is_supply_mon = (sel == `AFM_MON_ANLSUP) || (sel == `AFM_MON_DIGSUP);
    end
  endfunction

  // Monitor codes that switch the burnout sources on
  function is_burnout;
    input [2:0] sel;
    begin
      is_burnout = (sel >= `AFM_MON_BO_0U2);
    end
  endfunction

  assign mon_sel   = sysctl_q[`AFM_SYS_MON_HI:`AFM_SYS_MON_LO];
  assign conversion_ready_signal_fall = conversion_ready_signal_prev_q && !conversion_ready_signal_sync_q[1];
  // Amplifier bypassed: sense the converter input node
  assign rail_live = exc1_q[`AFM_EXC1_RAILMON] ? (misc_sync_q[1] ? adc_sync_q : rail_sync_q) : 4'h0;
  assign ref_live  = {ref_sync_q[1] & refctl_q[`AFM_REF_MONEN_HI],
                      ref_sync_q[0] & (|refctl_q[`AFM_REF_MONEN_HI:`AFM_REF_MONEN_LO])};
  // Bit 7 power-on, bit 6 not-ready, 5..2 rails, 1..0 reference
  assign status_byte = {por_flag_q, busy_meta_q[1], rail_flag_q, ref_flag_q};
  assign data_first_is_status_o = sysctl_q[`AFM_SYS_STATUS_PREPEND_ENABLE];

  // Per-pin read value: input pins show the synced pin, outputs the written bit
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_gpio_rd
      assign gpio_rd_val[g] = gpio_dat_q[4 + g] ? pin_sync_q[g] : gpio_dat_q[g];
    end
  endgenerate

////////////////////////////////////////////////////////////////////////////////
// Synchronisers

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      // Ready resets to its idle high level: no false fall after reset
      conversion_ready_signal_sync_q <= 2'h3;
      conversion_ready_signal_prev_q <= 1'b1;
      pin_meta_q  <= 4'h0;
      pin_sync_q  <= 4'h0;
      rail_meta_q <= 4'h0;
      rail_sync_q <= 4'h0;
      adc_meta_q  <= 4'h0;
      adc_sync_q  <= 4'h0;
      ref_meta_q  <= 2'h0;
      ref_sync_q  <= 2'h0;
      por_meta_q  <= 2'h0;
      busy_meta_q <= 2'h0;
      misc_meta_q <= 2'h0;
      misc_sync_q <= 2'h0;
    end else if (ce_i) begin
      conversion_ready_signal_sync_q <= {conversion_ready_signal_sync_q[0], conversion_ready_signal_i};
      conversion_ready_signal_prev_q <= conversion_ready_signal_sync_q[1];
      pin_meta_q  <= gpio_pin_i;
      pin_sync_q  <= pin_meta_q;
      // Both comparator sets and the bypass select pass the same two stages
      rail_meta_q <= rail_cmp_amp_i;
      rail_sync_q <= rail_meta_q;
      adc_meta_q  <= rail_cmp_adc_i;
      adc_sync_q  <= adc_meta_q;
      ref_meta_q  <= {ref_below_third_i, ref_below_fixed_i};
      ref_sync_q  <= ref_meta_q;
      por_meta_q  <= {por_meta_q[0], por_event_i};
      busy_meta_q <= {busy_meta_q[0], regmap_busy_i};
      misc_meta_q <= {amp_bypassed_i, sleep_command_i};
      misc_sync_q <= misc_meta_q;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Configuration and flag registers

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sysctl_q    <= `AFM_RST_SYSCTL;
      exc1_q      <= `AFM_RST_EXC1;
      refctl_q    <= `AFM_RST_REFCTL;
      gpio_dat_q  <= `AFM_RST_GPIO_DAT;
      gpio_con_q  <= `AFM_RST_GPIO_CON;
      por_flag_q  <= 1'b1;
      rail_flag_q <= 4'h0;
      rail_cap_q  <= 4'h0;
      ref_flag_q  <= 2'h0;
      ref_cap_q   <= 2'h0;
      sleep_q     <= 1'b0;
    end else if (ce_i) begin
      if (wr_hit(reg_addr_i, `AFM_ADDR_SYSCTL, reg_wr_i))
        sysctl_q <= reg_wdata_i;
      if (wr_hit(reg_addr_i, `AFM_ADDR_EXC1, reg_wr_i))
        exc1_q <= reg_wdata_i;
      if (wr_hit(reg_addr_i, `AFM_ADDR_REFCTL, reg_wr_i))
        refctl_q <= reg_wdata_i;
      if (wr_hit(reg_addr_i, `AFM_ADDR_GPIO_DAT, reg_wr_i))
        gpio_dat_q <= reg_wdata_i;
      if (wr_hit(reg_addr_i, `AFM_ADDR_GPIO_CON, reg_wr_i))
        gpio_con_q <= reg_wdata_i;
      // Power-on flag: a new power-on event wins over a clearing write
      if (por_meta_q[1])
        por_flag_q <= 1'b1;
      else if (wr_hit(reg_addr_i, `AFM_ADDR_STATUS, reg_wr_i) && !reg_wdata_i[`AFM_ST_POR])
        por_flag_q <= 1'b0;
      // Sleep holds the switch open until the register is rewritten
      if (misc_sync_q[0])
        sleep_q <= 1'b1;
      else if (wr_hit(reg_addr_i, `AFM_ADDR_EXC1, reg_wr_i))
        sleep_q <= 1'b0;
      // Accumulate faults over the cycle, publish on ready fall
      if (conversion_ready_signal_fall) begin
        rail_flag_q <= rail_cap_q | rail_live;
        ref_flag_q  <= ref_cap_q | ref_live;
        rail_cap_q  <= 4'h0;
        ref_cap_q   <= 2'h0;
      end else begin
        rail_cap_q  <= rail_cap_q | rail_live;
        ref_cap_q   <= ref_cap_q | ref_live;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Register read and data-read status byte

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o        <= 8'h00;
      data_status_byte_o <= 8'h00;
    end else if (ce_i) begin
      if (data_rd_start_i)
        data_status_byte_o <= status_byte;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `AFM_ADDR_STATUS:   reg_rdata_o <= status_byte;
          `AFM_ADDR_REFCTL:   reg_rdata_o <= refctl_q;
          `AFM_ADDR_EXC1:     reg_rdata_o <= exc1_q;
          `AFM_ADDR_SYSCTL:   reg_rdata_o <= sysctl_q;
          `AFM_ADDR_GPIO_DAT: reg_rdata_o <= {gpio_dat_q[7:4], gpio_rd_val};
          `AFM_ADDR_GPIO_CON: reg_rdata_o <= gpio_con_q;
          default:            reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Monitor routing, GPIO and switch outputs

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gpio_out_o                 <= 4'h0;
      gpio_oe_o                  <= 4'h0;
      gpio_function_select_o     <= 4'h0;
      monitor_select_o           <= `AFM_MON_OFF;
      inputs_disconnect_o        <= 1'b0;
      force_unity_gain_o         <= 1'b0;
      route_temp_o               <= 1'b0;
      route_analog_supply_o      <= 1'b0;
      route_logic_supply_o       <= 1'b0;
      supply_divider_o           <= `AFM_SUPPLY_DIV;
      burnout_sources_o          <= 3'h0;
      burnout_source_pos_o       <= 1'b0;
      burnout_sink_neg_o         <= 1'b0;
      ref_pull_together_o        <= 1'b0;
      reference_monitor_enable_o <= 2'h0;
      low_side_switch_close_o    <= 1'b0;
    end else if (ce_i) begin
      gpio_function_select_o     <= gpio_con_q[3:0];
      gpio_oe_o                  <= gpio_con_q[3:0] & ~gpio_dat_q[7:4];
      gpio_out_o                 <= gpio_dat_q[3:0];
      monitor_select_o           <= mon_sel;
      route_temp_o               <= (mon_sel == `AFM_MON_TEMP);
      route_analog_supply_o      <= (mon_sel == `AFM_MON_ANLSUP);
      route_logic_supply_o       <= (mon_sel == `AFM_MON_DIGSUP);
      inputs_disconnect_o        <= (mon_sel == `AFM_MON_TEMP) || is_supply_mon(mon_sel);
      force_unity_gain_o         <= is_supply_mon(mon_sel);
      supply_divider_o           <= `AFM_SUPPLY_DIV;
      burnout_sources_o          <= {mon_sel == `AFM_MON_BO_10U, mon_sel == `AFM_MON_BO_1U,
                                     mon_sel == `AFM_MON_BO_0U2};
      burnout_source_pos_o       <= is_burnout(mon_sel);
      burnout_sink_neg_o         <= is_burnout(mon_sel);
      ref_pull_together_o        <= refctl_q[2];
      reference_monitor_enable_o <= refctl_q[`AFM_REF_MONEN_HI:`AFM_REF_MONEN_LO];
      low_side_switch_close_o    <= exc1_q[`AFM_EXC1_PSW] && !sleep_q && !misc_sync_q[0];
    end
  end

endmodule

// >>> inc/afm_consts.vh
// Register offsets, field positions and reset values of the fault monitor block
`ifndef AFM_CONSTS_VH
`define AFM_CONSTS_VH
`define AFM_ADDR_STATUS      8'h01
`define AFM_ADDR_REFCTL      8'h05
`define AFM_ADDR_EXC1        8'h06
`define AFM_ADDR_SYSCTL      8'h09
`define AFM_ADDR_GPIO_DAT    8'h10
`define AFM_ADDR_GPIO_CON    8'h11
`define AFM_ST_POR           7
`define AFM_ST_NRDY          6
`define AFM_ST_RAIL_HI       5
`define AFM_ST_RAIL_LO       2
`define AFM_ST_REF_THIRD     1
`define AFM_ST_REF_FIXED     0
`define AFM_SYS_MON_HI       7
`define AFM_SYS_MON_LO       5
`define AFM_SYS_STATUS_PREPEND_ENABLE     0
`define AFM_EXC1_PSW         7
`define AFM_EXC1_RAILMON     6
`define AFM_REF_MONEN_HI     1
`define AFM_REF_MONEN_LO     0
`define AFM_MON_OFF          3'h0
`define AFM_MON_TEMP         3'h2
`define AFM_MON_ANLSUP       3'h3
`define AFM_MON_DIGSUP       3'h4
`define AFM_MON_BO_0U2       3'h5
`define AFM_MON_BO_1U        3'h6
`define AFM_MON_BO_10U       3'h7
`define AFM_RST_SYSCTL       8'h10
`define AFM_RST_EXC1         8'h00
`define AFM_RST_REFCTL       8'h00
`define AFM_RST_GPIO_DAT     8'h00
`define AFM_RST_GPIO_CON     8'h00
`define AFM_SUPPLY_DIV       3'h4
`endif

// >>> tb/afm_fault_monitor_checker.sv
// Port assertions for the fault monitor block
`timescale 1ns/1ps
module afm_fault_monitor_checker (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       ce_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       sleep_command_i,
  input wire logic [2:0] monitor_select_o,
  input wire logic       inputs_disconnect_o,
  input wire logic       force_unity_gain_o,
  input wire logic       route_temp_o,
  input wire logic       route_analog_supply_o,
  input wire logic       route_logic_supply_o,
  input wire logic [2:0] supply_divider_o,
  input wire logic [2:0] burnout_sources_o,
  input wire logic       burnout_source_pos_o,
  input wire logic       burnout_sink_neg_o,
  input wire logic       low_side_switch_close_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_anl;
    monitor_select_o == 3'h3 |-> route_analog_supply_o && !route_logic_supply_o && inputs_disconnect_o && force_unity_gain_o;
  endproperty
  a_anl: assert property (p_anl) else $error("analog supply routing wrong");
  property p_dig;
    monitor_select_o == 3'h4 |-> route_logic_supply_o && !route_analog_supply_o && inputs_disconnect_o && force_unity_gain_o;
  endproperty
  a_dig: assert property (p_dig) else $error("logic supply routing wrong");
  property p_div;
    supply_divider_o == 3'h4;
  endproperty
  a_div: assert property (p_div) else $error("supply divider not four");
  property p_bo;
    monitor_select_o >= 3'h5 |-> burnout_sources_o == (3'h1 << (monitor_select_o - 3'h5)) && burnout_source_pos_o && burnout_sink_neg_o;
  endproperty
  a_bo: assert property (p_bo) else $error("burnout source setting wrong");
  property p_temp;
    monitor_select_o == 3'h2 |-> route_temp_o && inputs_disconnect_o && burnout_sources_o == 3'h0;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature routing wrong");
  property p_off;
    monitor_select_o == 3'h0 |-> !inputs_disconnect_o && !route_temp_o && burnout_sources_o == 3'h0 && !burnout_source_pos_o;
  endproperty
  a_off: assert property (p_off) else $error("monitor off but path altered");
  property p_sleep;
    $rose(sleep_command_i) |-> ##[1:4] !low_side_switch_close_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("switch not opened on sleep");
  property p_unm;
    reg_rd_i && ce_i && reg_addr_i == 8'h7e |=> reg_rdata_o == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hold;
    !(reg_rd_i && ce_i) |=> $stable(reg_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data changed without read");
endmodule

// >>> tb/afm_conv_model.sv
// Converter side model: active-low conversion ready strobe on the link clock
`timescale 1ns/1ps
module afm_conv_model (
  input  wire clk_link_i,
  input  wire conv_req_i,
  output reg  conversion_ready_signal_o
);
  initial conversion_ready_signal_o = 1'b1;
  // Ready falls for one link cycle per requested conversion end
  always @(posedge clk_link_i) begin
    conversion_ready_signal_o <= !(conv_req_i && conversion_ready_signal_o);
  end
endmodule

// >>> tb/afm_fault_monitor_tb.sv
// Self-checking bench of the fault monitor block
`timescale 1ns/1ps
`include "afm_consts.vh"
module afm_fault_monitor_tb;
  reg        clk_sys_i, rst_n_i, clk_link, conv_req, busy, sleep_cmd, amp_byp, ref_fix, ref_thd, reg_wr, reg_rd, dstart;
  reg        por;
  reg  [3:0] rail_amp, rail_adc, pins;
  reg  [7:0] addr, wdata;
  wire [7:0] rdata, sbyte;
  wire [3:0] gout, goe, gfs;
  wire [2:0] msel, bo;
  wire       first, rdy_n, sw, pull;
  wire [1:0] rme;
  integer    error_cnt, tests_run, cyc, k, i;
  afm_fault_monitor afm_fault_monitor_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .por_event_i(por),
    .regmap_busy_i(busy), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .data_rd_start_i(dstart), .data_first_is_status_o(first), .data_status_byte_o(sbyte),
    .conversion_ready_signal_i(rdy_n), .sleep_command_i(sleep_cmd), .amp_bypassed_i(amp_byp), .rail_cmp_amp_i(rail_amp),
    .rail_cmp_adc_i(rail_adc), .ref_below_fixed_i(ref_fix), .ref_below_third_i(ref_thd), .gpio_pin_i(pins),
    .gpio_out_o(gout), .gpio_oe_o(goe), .gpio_function_select_o(gfs), .monitor_select_o(msel), .inputs_disconnect_o(),
    .force_unity_gain_o(), .route_temp_o(), .route_analog_supply_o(), .route_logic_supply_o(), .supply_divider_o(),
    .burnout_sources_o(bo), .burnout_source_pos_o(), .burnout_sink_neg_o(), .ref_pull_together_o(pull),
    .reference_monitor_enable_o(rme), .low_side_switch_close_o(sw));
  afm_conv_model afm_conv_model_inst (.clk_link_i(clk_link), .conv_req_i(conv_req), .conversion_ready_signal_o(rdy_n));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    clk_link = 1'b0;
    // Offset so link edges never share a time step with system clock edges
    #2;
    forever #32 clk_link = ~clk_link;
  end
  task check(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_sys_i);
      addr = a;
      wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys_i);
      reg_wr = 1'b0;
      repeat (2) @(negedge clk_sys_i);
    end
  endtask
  task rd(input [7:0] a, input [7:0] mask, input [7:0] exp);
    begin
      @(negedge clk_sys_i);
      addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys_i);
      reg_rd = 1'b0;
      @(negedge clk_sys_i);
      check(rdata & mask, exp);
    end
  endtask
  // One conversion end: ready strobe low, then time for sync and flag update
  task conv;
    begin
      @(negedge clk_sys_i);
      conv_req = 1'b1;
      for (i = 0; i < 40 && rdy_n; i = i + 1) @(negedge clk_sys_i);
      conv_req = 1'b0;
      repeat (12) @(negedge clk_sys_i);
    end
  endtask
  task finish_test;
    begin
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end
  initial begin
    {rst_n_i, por, conv_req, busy, sleep_cmd, amp_byp, ref_fix, ref_thd, reg_wr, reg_rd, dstart} = 11'h000;
    {rail_amp, rail_adc, pins, addr, wdata} = 28'h0;
    {error_cnt, tests_run, cyc} = 0;
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    rd(`AFM_ADDR_STATUS, 8'h80, 8'h80);
    busy = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    rd(`AFM_ADDR_STATUS, 8'h40, 8'h40);
    busy = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    // A power-on event during a clearing write leaves the flag set
    por = 1'b1;
    wr(`AFM_ADDR_STATUS, 8'h00);
    por = 1'b0;
    rd(`AFM_ADDR_STATUS, 8'h80, 8'h80);
    wr(`AFM_ADDR_STATUS, 8'h00);
    rd(`AFM_ADDR_STATUS, 8'hff, 8'h00);
    rd(`AFM_ADDR_SYSCTL, 8'hff, `AFM_RST_SYSCTL);
    rd(8'h7e, 8'hff, 8'h00);
    for (k = 0; k < 8; k = k + 1) begin
      wr(`AFM_ADDR_SYSCTL, {k[2:0], 5'h00});
      check({5'h00, msel}, k[7:0]);
      check({5'h00, bo}, (k >= 5) ? (8'h01 << (k - 5)) : 8'h00);
    end
    wr(`AFM_ADDR_SYSCTL, 8'h00);
    wr(`AFM_ADDR_EXC1, 8'h80);
    check({7'h00, sw}, 8'h01);
    @(negedge clk_sys_i) sleep_cmd = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    sleep_cmd = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    check({7'h00, sw}, 8'h00);
    wr(`AFM_ADDR_EXC1, 8'h40);
    rail_amp = 4'h8;
    repeat (2) @(negedge clk_sys_i);
    rail_amp = 4'h0;
    rd(`AFM_ADDR_STATUS, 8'hff, 8'h00);
    conv;
    rd(`AFM_ADDR_STATUS, 8'hff, 8'h20);
    conv;
    rd(`AFM_ADDR_STATUS, 8'hff, 8'h00);
    {amp_byp, rail_amp, rail_adc} = 9'h1f1;
    conv;
    rd(`AFM_ADDR_STATUS, 8'hff, 8'h04);
    // The fault seen before the disable still belongs to the running cycle
    wr(`AFM_ADDR_EXC1, 8'h00);
    conv;
    rd(`AFM_ADDR_STATUS, 8'hff, 8'h04);
    conv;
    rd(`AFM_ADDR_STATUS, 8'hff, 8'h00);
    {amp_byp, rail_amp, rail_adc, ref_fix, ref_thd} = 11'h003;
    wr(`AFM_ADDR_REFCTL, 8'h03);
    check({6'h00, rme}, 8'h03);
    conv;
    rd(`AFM_ADDR_STATUS, 8'hff, 8'h03);
    wr(`AFM_ADDR_SYSCTL, 8'h01);
    check({7'h00, first}, 8'h01);
    @(negedge clk_sys_i) dstart = 1'b1;
    @(negedge clk_sys_i) dstart = 1'b0;
    check(sbyte, 8'h03);
    // Faults latched before the disable are still published once
    wr(`AFM_ADDR_REFCTL, 8'h00);
    conv;
    rd(`AFM_ADDR_STATUS, 8'hff, 8'h03);
    conv;
    rd(`AFM_ADDR_STATUS, 8'hff, 8'h00);
    wr(`AFM_ADDR_REFCTL, 8'h04);
    check({7'h00, pull}, 8'h01);
    wr(`AFM_ADDR_REFCTL, 8'h00);
    check({7'h00, pull}, 8'h00);
    wr(`AFM_ADDR_GPIO_CON, 8'h0f);
    check({4'h0, gfs}, 8'h0f);
    pins = 4'h8;
    wr(`AFM_ADDR_GPIO_DAT, 8'hc5);
    check({goe, gout & 4'h3}, 8'h31);
    rd(`AFM_ADDR_GPIO_DAT, 8'hff, 8'hc9);
    finish_test;
  end
endmodule
bind afm_fault_monitor afm_fault_monitor_checker afm_fault_monitor_checker_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .ce_i(ce_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .sleep_command_i(sleep_command_i),
  .monitor_select_o(monitor_select_o), .inputs_disconnect_o(inputs_disconnect_o), .force_unity_gain_o(force_unity_gain_o),
  .route_temp_o(route_temp_o), .route_analog_supply_o(route_analog_supply_o), .route_logic_supply_o(route_logic_supply_o),
  .supply_divider_o(supply_divider_o), .burnout_sources_o(burnout_sources_o), .burnout_source_pos_o(burnout_source_pos_o),
  .burnout_sink_neg_o(burnout_sink_neg_o), .low_side_switch_close_o(low_side_switch_close_o));
